/* core/dtb_core.sv */
// Down timer with prescaler, PWM, underflow toggle and tone outputs behind an AXI4-Lite slave.
// Assumes all inputs are synchronous to mclk; the pad logic resolves the pin enables.
//
// Contract
// [R01] Count read returns live low eight bits.
// [R02] Count write loads reload byte and counter.
// [R03] Free mode reloads 0x3FF on underflow.
// [R04] Auto-reload mode reloads programmed value on underflow.
// [R05] One-shot stops counting after first underflow.
// [R06] Run, auto-reload, one-shot bits; cleared at reset.
// [R07] Polarity bit sets PWM active level.
// [R08] PWM enable drives PWM pin, else released.
// [R09] Toggle inverts on underflow, drives shared pin.
// [R10] Shared pin: toggle, then comparator, then tone.
// [R11] Reload sets period; duty from high bits, byte.
// [R12] Rate field divides 1:2 up to 1:256.
// [R13] Active-low prescaler enable, bypass when one.
// [R14] Software changes rate only while prescaler disabled.
// [R15] Source bit picks external pin or clock.
// [R16] Edge bit picks falling or rising external edge.
// [R17] Prescaler value register reads live count.
// [R18] Tone picks prescaler tap or timer bit.
// [R19] Disabled timer holds value, no underflow.
// [R20] Underflow raises event flag for interrupts.
`timescale 1ns/1ps
`default_nettype none

module dtb_core (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire dtb_pkg::dtb_axi_req_t axiReq,
    output dtb_pkg::dtb_axi_rsp_t axiRsp,
    input wire logic extCountClockPin,
    input wire logic comparatorPinEnable,
    input wire logic cmpOutLevel,
    input wire logic tone1Enable,
    input wire logic tone1Level,
    output dtb_pkg::dtb_pins_t pinOut
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic isMapped(input logic [dtb_pkg::IDX_W-1:0] idx);
        isMapped = (idx >= dtb_pkg::IDX_COUNT) && (idx <= dtb_pkg::IDX_RELOAD_HI);
    endfunction

    function automatic logic [dtb_pkg::PS_W-1:0] rateMask(input logic [2:0] sel);
        logic [dtb_pkg::PS_W-1:0] m;
        m = '0;
        for (int i = 0; i < dtb_pkg::PS_W; i++) begin
            m[i] = (i <= int'(sel)); // R12
        end
        rateMask = m;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dtb_pkg::dtb_state_t state_r;
    dtb_pkg::dtb_state_t state_nxt;
    logic srcTick;
    logic tick;
    logic underflow;
    logic doWrite;
    logic wrEn;
    logic wrCount;
    logic [dtb_pkg::CNT_W-1:0] reloadVal;
    logic [dtb_pkg::CNT_W-1:0] dutyVal;
    logic [dtb_pkg::CNT_W-1:0] loadVal;
    logic [7:0] readByte;
    logic [3:0] toneSel;
    logic toneTap;
    logic [dtb_pkg::IDX_W-1:0] rdIdx;

    assign axiRsp = state_r.rsp;
    assign pinOut = state_r.pins;

    always_comb begin
        state_nxt = state_r;
        srcTick = 1'b0;
        tick = 1'b0;
        underflow = 1'b0;
        readByte = 8'h00;
        toneSel = state_r.tone[dtb_pkg::TONE_SEL_MSB:dtb_pkg::TONE_SEL_LSB];
        toneTap = 1'b0;
        rdIdx = axiReq.araddr[dtb_pkg::ADDR_W-1:dtb_pkg::IDX_LSB];
        reloadVal = {state_r.reloadHi[dtb_pkg::RH_PERIOD_MSB:dtb_pkg::RH_PERIOD_LSB], state_r.reloadLo}; // R11
        dutyVal = {state_r.reloadHi[dtb_pkg::RH_DUTY_MSB:dtb_pkg::RH_DUTY_LSB], state_r.dutyLo}; // R11
        loadVal = {state_r.reloadHi[dtb_pkg::RH_PERIOD_MSB:dtb_pkg::RH_PERIOD_LSB], state_r.wData};
        doWrite = state_r.awHeld && state_r.wHeld && !state_r.rsp.bvalid;
        wrEn = doWrite && state_r.wStrb0 && isMapped(state_r.wIdx);
        wrCount = wrEn && (state_r.wIdx == dtb_pkg::IDX_COUNT);
        state_nxt.pins.underflowEvent = 1'b0;

        // ------------------------------------------------------------
        // Count source and prescaler
        // ------------------------------------------------------------
        // The external pin is sampled as is, so an edge is a change between two clock samples.
        state_nxt.extPrev = extCountClockPin;
        if (state_r.ctl2[dtb_pkg::CTL2_SOURCE_BIT]) begin // R15
            if (state_r.ctl2[dtb_pkg::CTL2_EDGE_BIT]) begin
                srcTick = state_r.extPrev && !extCountClockPin; // R16
            end else begin
                srcTick = !state_r.extPrev && extCountClockPin; // R16
            end
        end else begin
            srcTick = 1'b1;
        end
        if (state_r.ctl1[dtb_pkg::CTL1_RUN_BIT]) begin // R06 R19
            if (state_r.ctl2[dtb_pkg::CTL2_PRESCALE_DIS_BIT]) begin
                tick = srcTick; // R13
            end else begin
                // A changed rate can match a partial count at once; software avoids this.
                tick = srcTick
                    && ((state_r.ps & rateMask(state_r.ctl2[dtb_pkg::CTL2_RATE_MSB:dtb_pkg::CTL2_RATE_LSB]))
                    == '0); // R12
                if (srcTick) begin
                    state_nxt.ps = state_r.ps - 8'h01; // R13
                end
            end
        end

        // ------------------------------------------------------------
        // Down counter
        // ------------------------------------------------------------
        if (tick && !state_r.oneShotDone && !wrCount) begin
            if (state_r.count == dtb_pkg::CNT_ZERO) begin
                underflow = 1'b1;
                if (state_r.ctl1[dtb_pkg::CTL1_ONE_SHOT_BIT]) begin
                    state_nxt.oneShotDone = 1'b1; // R05
                end else if (state_r.ctl1[dtb_pkg::CTL1_AUTO_RELOAD_BIT]) begin
                    state_nxt.count = reloadVal; // R04
                end else begin
                    state_nxt.count = dtb_pkg::CNT_MAX; // R03
                end
            end else begin
                state_nxt.count = state_r.count - 10'h001;
            end
        end
        if (underflow) begin
            state_nxt.toggle = !state_r.toggle; // R09
            state_nxt.pins.underflowEvent = 1'b1; // R20
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (axiRsp.awready && axiReq.awvalid) begin
            state_nxt.awHeld = 1'b1;
            state_nxt.wIdx = axiReq.awaddr[dtb_pkg::ADDR_W-1:dtb_pkg::IDX_LSB];
        end
        if (axiRsp.wready && axiReq.wvalid) begin
            state_nxt.wHeld = 1'b1;
            state_nxt.wData = axiReq.wdata[7:0];
            state_nxt.wStrb0 = axiReq.wstrb[0];
        end
        if (state_r.rsp.bvalid && axiReq.bready) begin
            state_nxt.rsp.bvalid = 1'b0;
        end
        if (doWrite) begin
            state_nxt.awHeld = 1'b0;
            state_nxt.wHeld = 1'b0;
            state_nxt.rsp.bvalid = 1'b1;
            state_nxt.rsp.bresp = isMapped(state_r.wIdx) ? dtb_pkg::RESP_OKAY : dtb_pkg::RESP_SLVERR;
        end
        if (wrEn) begin
            case (state_r.wIdx)
                dtb_pkg::IDX_COUNT: begin
                    state_nxt.reloadLo = state_r.wData; // R02
                    state_nxt.count = loadVal; // R02
                    state_nxt.oneShotDone = 1'b0;
                end
                dtb_pkg::IDX_CTL1: begin
                    state_nxt.ctl1 = state_r.wData & dtb_pkg::CTL1_MASK; // R06
                end
                dtb_pkg::IDX_CTL2: begin
                    state_nxt.ctl2 = state_r.wData & dtb_pkg::CTL2_MASK;
                end
                dtb_pkg::IDX_DUTY: begin
                    state_nxt.dutyLo = state_r.wData;
                end
                dtb_pkg::IDX_TONE: begin
                    state_nxt.tone = state_r.wData & dtb_pkg::TONE_MASK;
                end
                dtb_pkg::IDX_RELOAD_HI: begin
                    state_nxt.reloadHi = state_r.wData & dtb_pkg::RH_MASK;
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        case (rdIdx)
            dtb_pkg::IDX_COUNT: readByte = state_r.count[7:0]; // R01
            dtb_pkg::IDX_CTL1: readByte = state_r.ctl1;
            dtb_pkg::IDX_CTL2: readByte = state_r.ctl2;
            dtb_pkg::IDX_PRESC: readByte = state_r.ps; // R17
            dtb_pkg::IDX_RELOAD_HI: readByte = state_r.reloadHi;
            default: readByte = 8'h00;
        endcase
        if (state_r.rsp.rvalid && axiReq.rready) begin
            state_nxt.rsp.rvalid = 1'b0;
        end
        if (axiRsp.arready && axiReq.arvalid) begin
            state_nxt.rsp.rvalid = 1'b1;
            state_nxt.rsp.rdata = {24'h000000, readByte};
            state_nxt.rsp.rresp = isMapped(rdIdx) ? dtb_pkg::RESP_OKAY : dtb_pkg::RESP_SLVERR;
        end
        state_nxt.rsp.awready = !state_nxt.awHeld && !state_nxt.rsp.bvalid;
        state_nxt.rsp.wready = !state_nxt.wHeld && !state_nxt.rsp.bvalid;
        state_nxt.rsp.arready = !state_nxt.rsp.rvalid;

        // ------------------------------------------------------------
        // Pin outputs
        // ------------------------------------------------------------
        state_nxt.pins.pwmPinOut = (state_r.count < dutyVal) ^ state_r.ctl1[dtb_pkg::CTL1_PWM_ACTIVE_LOW_BIT]; // R07
        state_nxt.pins.pwmPinOe = state_r.ctl1[dtb_pkg::CTL1_PWM_PIN_BIT]; // R08
        if (state_r.ctl1[dtb_pkg::CTL1_TOGGLE_PIN_BIT]) begin // R10
            state_nxt.pins.sharedPinOut = state_r.toggle; // R09
            state_nxt.pins.sharedPinOe = 1'b1;
        end else if (comparatorPinEnable) begin // R10
            state_nxt.pins.sharedPinOut = cmpOutLevel;
            state_nxt.pins.sharedPinOe = 1'b1;
        end else if (tone1Enable) begin
            state_nxt.pins.sharedPinOut = tone1Level;
            state_nxt.pins.sharedPinOe = 1'b1;
        end else begin
            state_nxt.pins.sharedPinOut = 1'b0;
            state_nxt.pins.sharedPinOe = 1'b0;
        end
        if (toneSel[dtb_pkg::TONE_SRC_BIT]) begin
            toneTap = state_r.count[toneSel[2:0]]; // R18
        end else begin
            toneTap = state_r.ps[toneSel[2:0]]; // R18
        end
        state_nxt.pins.toneOut = state_r.tone[dtb_pkg::TONE_ENABLE_BIT] && toneTap; // R18

        // ------------------------------------------------------------
        // Synchronous reset
        // ------------------------------------------------------------
        if (sys_rst) begin
            state_nxt = '0;
            state_nxt.ctl1 = dtb_pkg::CTL1_RESET; // R06
            state_nxt.ctl2 = dtb_pkg::CTL2_RESET; // R13
            state_nxt.tone = dtb_pkg::TONE_RESET;
            state_nxt.reloadHi = dtb_pkg::RH_RESET;
            state_nxt.ps = dtb_pkg::PS_RESET; // R17
            state_nxt.rsp.awready = 1'b1;
            state_nxt.rsp.wready = 1'b1;
            state_nxt.rsp.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        state_r <= state_nxt;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_count_read: assert property ( // R01
        (axiRsp.arready && axiReq.arvalid && rdIdx == dtb_pkg::IDX_COUNT)
        |=> (state_r.rsp.rvalid && state_r.rsp.rdata[7:0] == $past(state_r.count[7:0])))
        else $error("count read did not return live count");

    a_count_load: assert property ( // R02
        wrCount |=> (state_r.count == $past(loadVal) && state_r.reloadLo == $past(state_r.wData)))
        else $error("count write did not load counter");

    a_free_reload: assert property ( // R03
        (underflow && !state_r.ctl1[dtb_pkg::CTL1_ONE_SHOT_BIT] && !state_r.ctl1[dtb_pkg::CTL1_AUTO_RELOAD_BIT])
        |=> state_r.count == dtb_pkg::CNT_MAX)
        else $error("free mode did not reload full count");

    a_auto_reload: assert property ( // R04
        (underflow && !state_r.ctl1[dtb_pkg::CTL1_ONE_SHOT_BIT] && state_r.ctl1[dtb_pkg::CTL1_AUTO_RELOAD_BIT])
        |=> state_r.count == $past(reloadVal))
        else $error("auto reload value not loaded");

    a_one_shot_stop: assert property ( // R05
        (underflow && state_r.ctl1[dtb_pkg::CTL1_ONE_SHOT_BIT])
        ##1 (!wrEn) [*2] |-> (state_r.count == dtb_pkg::CNT_ZERO && !underflow))
        else $error("one-shot kept counting");

    a_hold_disabled: assert property ( // R19
        (!state_r.ctl1[dtb_pkg::CTL1_RUN_BIT] && !wrCount) |=> ($stable(state_r.count) && !state_r.pins.underflowEvent))
        else $error("disabled timer changed");

    a_toggle_event: assert property ( // R09
        underflow |=> (state_r.toggle != $past(state_r.toggle) && state_r.pins.underflowEvent))
        else $error("underflow did not toggle and flag");

    a_event_only: assert property ( // R20
        state_r.pins.underflowEvent |-> $past(underflow))
        else $error("event flag without underflow");

    a_pwm_level: assert property ( // R07
        1'b1 |=> state_r.pins.pwmPinOut ==
        ($past(state_r.count < dutyVal) ^ $past(state_r.ctl1[dtb_pkg::CTL1_PWM_ACTIVE_LOW_BIT])))
        else $error("pwm level wrong");

    a_pwm_release: assert property ( // R08
        !state_r.ctl1[dtb_pkg::CTL1_PWM_PIN_BIT] |=> !state_r.pins.pwmPinOe)
        else $error("pwm pin driven while disabled");

    a_shared_prio: assert property ( // R10
        state_r.ctl1[dtb_pkg::CTL1_TOGGLE_PIN_BIT]
        |=> (state_r.pins.sharedPinOe && state_r.pins.sharedPinOut == $past(state_r.toggle)))
        else $error("toggle lost shared pin");

    a_prescale_bypass: assert property ( // R13
        state_r.ctl2[dtb_pkg::CTL2_PRESCALE_DIS_BIT] |=> $stable(state_r.ps))
        else $error("bypassed prescaler moved");

    a_count_step: assert property ( // R03
        (tick && !state_r.oneShotDone && !wrCount && state_r.count != dtb_pkg::CNT_ZERO)
        |=> state_r.count == $past(state_r.count) - 10'h001)
        else $error("counter did not step down on tick");

    a_ps_count: assert property ( // R13
        (state_r.ctl1[dtb_pkg::CTL1_RUN_BIT] && !state_r.ctl2[dtb_pkg::CTL2_PRESCALE_DIS_BIT]
        && !state_r.ctl2[dtb_pkg::CTL2_SOURCE_BIT]) |=> state_r.ps == $past(state_r.ps) - 8'h01)
        else $error("enabled prescaler did not count");

    a_pwm_enable: assert property ( // R08
        state_r.ctl1[dtb_pkg::CTL1_PWM_PIN_BIT] |=> state_r.pins.pwmPinOe)
        else $error("pwm pin not driven while enabled");

    a_cmp_over_tone: assert property ( // R10
        (!state_r.ctl1[dtb_pkg::CTL1_TOGGLE_PIN_BIT] && comparatorPinEnable)
        |=> (state_r.pins.sharedPinOe && state_r.pins.sharedPinOut == $past(cmpOutLevel)))
        else $error("comparator lost shared pin");

    a_shared_idle: assert property ( // R09
        (!state_r.ctl1[dtb_pkg::CTL1_TOGGLE_PIN_BIT] && !comparatorPinEnable && !tone1Enable)
        |=> !state_r.pins.sharedPinOe)
        else $error("shared pin driven with no owner");

    a_tone_off: assert property ( // R18
        !state_r.tone[dtb_pkg::TONE_ENABLE_BIT] |=> !state_r.pins.toneOut)
        else $error("tone output active while disabled");

    a_reset_state: assert property ( // R06
        $fell(sys_rst) |-> (state_r.ctl1 == dtb_pkg::CTL1_RESET && state_r.ps == dtb_pkg::PS_RESET))
        else $error("control or prescaler not at reset value");

    c_underflow: cover property (underflow);
    c_one_shot: cover property ($rose(state_r.oneShotDone));
    c_write_done: cover property (doWrite);
    c_read_done: cover property (state_r.rsp.rvalid && axiReq.rready);

endmodule

`default_nettype wire

/* shared/dtb_pkg.sv */
// Constants, register map and carrier types for the down timer with PWM and tone outputs.
// Assumes a 32-bit AXI4-Lite master with 8-bit byte addresses; registers sit at four times their index.
package dtb_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 10;
    localparam int PS_W = 8;
    localparam int IDX_W = 6;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_COUNT = 6'h10;
    localparam logic [IDX_W-1:0] IDX_CTL1 = 6'h11;
    localparam logic [IDX_W-1:0] IDX_CTL2 = 6'h12;
    localparam logic [IDX_W-1:0] IDX_DUTY = 6'h13;
    localparam logic [IDX_W-1:0] IDX_PRESC = 6'h14;
    localparam logic [IDX_W-1:0] IDX_TONE = 6'h15;
    localparam logic [IDX_W-1:0] IDX_RELOAD_HI = 6'h16;
    localparam int IDX_LSB = 2;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL1_RUN_BIT = 0;
    localparam int CTL1_AUTO_RELOAD_BIT = 1;
    localparam int CTL1_ONE_SHOT_BIT = 2;
    localparam int CTL1_TOGGLE_PIN_BIT = 5;
    localparam int CTL1_PWM_ACTIVE_LOW_BIT = 6;
    localparam int CTL1_PWM_PIN_BIT = 7;
    localparam int CTL2_RATE_MSB = 2;
    localparam int CTL2_RATE_LSB = 0;
    localparam int CTL2_PRESCALE_DIS_BIT = 3;
    localparam int CTL2_EDGE_BIT = 4;
    localparam int CTL2_SOURCE_BIT = 5;
    localparam int TONE_ENABLE_BIT = 7;
    localparam int TONE_SEL_MSB = 3;
    localparam int TONE_SEL_LSB = 0;
    localparam int TONE_SRC_BIT = 3;
    localparam int RH_PERIOD_MSB = 5;
    localparam int RH_PERIOD_LSB = 4;
    localparam int RH_DUTY_MSB = 1;
    localparam int RH_DUTY_LSB = 0;

    // ----------------------------------------------------------------
    // Writable masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTL1_MASK = 8'hE7;
    localparam logic [7:0] CTL2_MASK = 8'h3F;
    localparam logic [7:0] TONE_MASK = 8'h8F;
    localparam logic [7:0] RH_MASK = 8'h33;
    localparam logic [7:0] CTL1_RESET = 8'h00;
    localparam logic [7:0] CTL2_RESET = 8'h3F;
    localparam logic [7:0] TONE_RESET = 8'h0F;
    localparam logic [7:0] RH_RESET = 8'h00;
    localparam logic [PS_W-1:0] PS_RESET = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } dtb_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } dtb_axi_rsp_t;

    typedef struct packed {
        logic pwmPinOut;
        logic pwmPinOe;
        logic sharedPinOut;
        logic sharedPinOe;
        logic toneOut;
        logic underflowEvent;
    } dtb_pins_t;

    typedef struct packed {
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] tone;
        logic [7:0] reloadHi;
        logic [7:0] reloadLo;
        logic [7:0] dutyLo;
        logic [CNT_W-1:0] count;
        logic [PS_W-1:0] ps;
        logic oneShotDone;
        logic toggle;
        logic extPrev;
        logic awHeld;
        logic wHeld;
        logic [IDX_W-1:0] wIdx;
        logic [7:0] wData;
        logic wStrb0;
        dtb_axi_rsp_t rsp;
        dtb_pins_t pins;
    } dtb_state_t;

endpackage

/* test/dtb_core_bench.sv */
// Self-checking bench for the down timer core: AXI4-Lite register tasks, timing and pin checks.
// Assumes registers sit at four times their index and every pin output is registered.
`timescale 1ns/1ps
`default_nettype none

module dtb_core_bench;
    localparam logic [5:0] ICNT = dtb_pkg::IDX_COUNT;
    localparam logic [5:0] IC1 = dtb_pkg::IDX_CTL1;
    localparam logic [5:0] IC2 = dtb_pkg::IDX_CTL2;
    localparam logic [5:0] IRH = dtb_pkg::IDX_RELOAD_HI;
    localparam logic [5:0] IPS = dtb_pkg::IDX_PRESC;
    localparam int LIMIT = 20000;
    logic mclk;
    logic sys_rst;
    dtb_pkg::dtb_axi_req_t req;
    dtb_pkg::dtb_axi_rsp_t rsp;
    dtb_pkg::dtb_pins_t pins;
    logic extPin, cmpEn, cmpLvl, t1En, t1Lvl, t;
    logic [31:0] rd, rs;
    int errTotal, compares, cycles, gap;

    dtb_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .axiReq(req), .axiRsp(rsp), .extCountClockPin(extPin),
        .comparatorPinEnable(cmpEn), .cmpOutLevel(cmpLvl), .tone1Enable(t1En), .tone1Level(t1Lvl), .pinOut(pins));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Compare, bus and wait tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("TB: errors=%0d compares=%0d", errTotal, compares);
        if (errTotal == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_gap(input int got, input int exp);
        compares++;
        if (got != exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data are offered together and each is dropped at the edge that takes it.
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [31:0] resp);
        logic aDone, wDone;
        aDone = 1'b0;
        wDone = 1'b0;
        @(posedge mclk);
        req.awvalid <= 1'b1;
        req.awaddr <= {idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        while (!(aDone && wDone)) begin
            @(negedge mclk);
            aDone = aDone || rsp.awready;
            wDone = wDone || rsp.wready;
            @(posedge mclk);
            if (aDone) req.awvalid <= 1'b0;
            if (wDone) req.wvalid <= 1'b0;
        end
        req.bready <= 1'b1;
        do @(negedge mclk); while (rsp.bvalid !== 1'b1);
        resp = {30'h0, rsp.bresp};
        @(posedge mclk);
        req.bready <= 1'b0;
    endtask

    task automatic rdr(input logic [5:0] idx, output logic [31:0] d, output logic [31:0] resp);
        @(posedge mclk);
        req.arvalid <= 1'b1;
        req.araddr <= {idx, 2'b00};
        do @(negedge mclk); while (rsp.arready !== 1'b1);
        @(posedge mclk);
        req.arvalid <= 1'b0;
        req.rready <= 1'b1;
        do @(negedge mclk); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        resp = {30'h0, rsp.rresp};
        @(posedge mclk);
        req.rready <= 1'b0;
    endtask

    task automatic wrk(input logic [5:0] idx, input logic [7:0] d);
        wr(idx, d, rs);
        chk_reg(rs, {30'h0, dtb_pkg::RESP_OKAY});
    endtask

    task automatic rd_exp(input logic [5:0] idx, input logic [31:0] exp);
        rdr(idx, rd, rs);
        chk_reg(rs, {30'h0, dtb_pkg::RESP_OKAY});
        chk_reg(rd, exp);
    endtask

    // Returns the number of cycles up to the next underflow pulse, or lim if none came.
    task automatic uf_wait(input int lim, output int n);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (pins.underflowEvent !== 1'b1 && n < lim);
    endtask

    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask

    task automatic ext_set(input logic v);
        @(posedge mclk);
        extPin <= v;
        repeat (4) @(negedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            errTotal++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        req = '0;
        {extPin, cmpEn, cmpLvl, t1En, t1Lvl} = 5'h00;
        {errTotal, compares, cycles} = {32'd0, 32'd0, 32'd0};
        sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_exp(IC1, 32'h00);
        rd_exp(IC2, 32'h3F);
        rd_exp(IPS, 32'hFF);
        wrk(IPS, 8'h00);
        rd_exp(IPS, 32'hFF);
        wr(6'h20, 8'h55, rs);
        chk_reg(rs, {30'h0, dtb_pkg::RESP_SLVERR});
        rdr(6'h20, rd, rs);
        chk_reg(rs, {30'h0, dtb_pkg::RESP_SLVERR});
        wrk(IC2, 8'h08);
        wrk(IRH, 8'h00);
        wrk(ICNT, 8'h20);
        repeat (10) @(posedge mclk);
        rd_exp(ICNT, 32'h20);
        wrk(dtb_pkg::IDX_DUTY, 8'h30);
        wrk(IC1, 8'h80);
        settle();
        chk_pin(pins.pwmPinOe, 1'b1);
        chk_pin(pins.pwmPinOut, 1'b1);
        wrk(IC1, 8'hC0);
        settle();
        chk_pin(pins.pwmPinOut, 1'b0);
        wrk(dtb_pkg::IDX_DUTY, 8'h10);
        settle();
        chk_pin(pins.pwmPinOut, 1'b1);
        wrk(IRH, 8'h01);
        settle();
        chk_pin(pins.pwmPinOut, 1'b0);
        wrk(IC1, 8'h00);
        settle();
        chk_pin(pins.pwmPinOe, 1'b0);
        // With the timer stopped the prescaler stays at all ones, so every prescaler tap reads high.
        for (int s = 0; s < 16; s++) begin
            wrk(dtb_pkg::IDX_TONE, 8'h80 | 8'(s));
            settle();
            chk_pin(pins.toneOut, (s < 8) ? 1'b1 : 1'(8'h20 >> (s - 8)));
        end
        wrk(dtb_pkg::IDX_TONE, 8'h0D);
        settle();
        chk_pin(pins.toneOut, 1'b0);
        @(posedge mclk);
        {cmpEn, cmpLvl, t1En, t1Lvl} <= 4'hE;
        settle();
        chk_pin(pins.sharedPinOe, 1'b1);
        chk_pin(pins.sharedPinOut, 1'b1);
        @(posedge mclk);
        cmpEn <= 1'b0;
        settle();
        chk_pin(pins.sharedPinOut, 1'b0);
        wrk(IC1, 8'h20);
        settle();
        t = pins.sharedPinOut;
        @(posedge mclk);
        {cmpEn, cmpLvl, t1En, t1Lvl} <= {1'b1, ~t, 1'b1, ~t};
        settle();
        chk_pin(pins.sharedPinOut, t);
        wrk(IC2, 8'h28);
        wrk(ICNT, 8'h08);
        wrk(IC1, 8'h21);
        ext_set(1'b1);
        rd_exp(ICNT, 32'h07);
        ext_set(1'b0);
        rd_exp(ICNT, 32'h07);
        wrk(IC2, 8'h38);
        ext_set(1'b1);
        rd_exp(ICNT, 32'h07);
        ext_set(1'b0);
        rd_exp(ICNT, 32'h06);
        wrk(IC2, 8'h08);
        wrk(ICNT, 8'h04);
        wrk(IC1, 8'h23);
        uf_wait(100, gap);
        uf_wait(100, gap);
        chk_gap(gap, 5);
        settle();
        t = pins.sharedPinOut;
        uf_wait(100, gap);
        settle();
        chk_pin(pins.sharedPinOut, ~t);
        // The rate is only changed while the prescaler is bypassed.
        for (int r = 0; r < 8; r++) begin
            if (r > 0) begin
                wrk(IC2, 8'h08 | 8'(r - 1));
            end
            wrk(IC2, 8'h08 | 8'(r));
            wrk(IC2, 8'(r));
            uf_wait(3000, gap);
            uf_wait(3000, gap);
            chk_gap(gap, 5 << (r + 1));
        end
        wrk(IC2, 8'h08);
        wrk(IRH, 8'h10);
        rd_exp(IRH, 32'h10);
        wrk(ICNT, 8'h04);
        uf_wait(400, gap);
        uf_wait(400, gap);
        chk_gap(gap, 261);
        wrk(IC1, 8'h01);
        uf_wait(2000, gap);
        uf_wait(2000, gap);
        chk_gap(gap, 1024);
        wrk(IC1, 8'h05);
        wrk(ICNT, 8'h03);
        uf_wait(2000, gap);
        uf_wait(2000, gap);
        chk_gap(gap, 2000);
        rd_exp(ICNT, 32'h00);
        tally_and_finish();
    end
endmodule

`default_nettype wire
